// [include/gate_pkg.sv]
package gate_pkg;

   // ==========================================================
   // Register port
   // ==========================================================
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 8;

   localparam logic [ADDR_W-1:0] GATE_CTRL_OFFSET  = 4'h0;
   localparam logic [ADDR_W-1:0] TIMER_CTRL_OFFSET = 4'h1;

   // ==========================================================
   // Field positions
   // ==========================================================
   localparam int unsigned GATE_ENABLE_BIT   = 7;
   localparam int unsigned GATE_POLARITY_BIT = 6;
   localparam int unsigned TOGGLE_MODE_BIT   = 5;
   localparam int unsigned SINGLE_PULSE_BIT  = 4;
   localparam int unsigned GO_DONE_BIT       = 3;
   localparam int unsigned LEVEL_BIT         = 2;
   localparam int unsigned SOURCE_MSB        = 1;
   localparam int unsigned SOURCE_LSB        = 0;
   localparam int unsigned TIMER_ON_BIT      = 0;

   // ==========================================================
   // Gate sources
   // ==========================================================
   localparam logic [1:0] SRC_PIN        = 2'h0;
   localparam logic [1:0] SRC_T0_OVF     = 2'h1;
   localparam logic [1:0] SRC_COMPARATOR = 2'h2;

   // ==========================================================
   // Reset values
   // ==========================================================
   localparam logic       RESET_BIT   = 1'h0;
   localparam logic [1:0] RESET_SRC   = 2'h0;
   localparam logic [7:0] RESET_RDATA = 8'h00;

   typedef struct packed {
      logic       gate_enable;
      logic       gate_polarity;
      logic       gate_toggle_mode;
      logic       gate_single_pulse_mode;
      logic       single_pulse_go_done;
      logic [1:0] gate_source_select;
   } gate_ctrl_t;

   localparam gate_ctrl_t RESET_CTRL = '{RESET_BIT, RESET_BIT, RESET_BIT, RESET_BIT, RESET_BIT, RESET_SRC};

   typedef enum logic [1:0] {
      SP_IDLE = 2'b00,
      SP_WAIT = 2'b01,
      SP_OPEN = 2'b10
   } sp_state_t;

endpackage : gate_pkg

// [verilog/pin_sync.sv]
`timescale 1ns/1ps
module pin_sync
   import gate_pkg::*;
(
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   input  wire logic ce_in,
   input  wire logic async_in,
   output logic      level_out
);

   logic [2:0] stage;
   logic [2:0] next_stage;
   logic       next_level;

   // ==========================================================
   // Three flops; a change counts once the last two agree
   // ==========================================================
   always_comb begin
      next_stage = {stage[1:0], async_in};
      next_level = (stage[1] == stage[2]) ? stage[2] : level_out;
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         stage     <= 3'h0;
         level_out <= RESET_BIT;
      end else if (ce_in) begin
         stage     <= next_stage;
         level_out <= next_level;
      end
   end

endmodule : pin_sync

// [verilog/timer_gate_control.sv]
`timescale 1ns/1ps
module timer_gate_control
   import gate_pkg::*;
(
   input  wire logic              clk_in,
   input  wire logic              rst_n_in,
   input  wire logic              ce_in,
   input  wire logic [ADDR_W-1:0] addr_in,
   input  wire logic [DATA_W-1:0] wdata_in,
   input  wire logic              wr_in,
   input  wire logic              rd_in,
   input  wire logic              gate_pin_in,
   input  wire logic              t0_overflow_in,
   input  wire logic              comparator_in,
   output logic [DATA_W-1:0]      rdata_out,
   output logic                   count_enable_out,
   output logic                   gate_level_out,
   output logic                   timer_on_out,
   output logic                   go_done_out
);

   // ==========================================================
   // Declarations
   // ==========================================================
   gate_ctrl_t  ctrl;
   gate_ctrl_t  next_ctrl;
   logic        timer_on;
   logic        next_timer_on;
   logic [DATA_W-1:0] next_rdata;

   logic        pin_level;
   logic        cmp_level;
   logic        src_level;
   logic        pol_level;
   logic        prev_pol;
   logic        next_prev_pol;
   logic        toggle_ff;
   logic        next_toggle_ff;
   logic        stage_level;
   logic        prev_stage;
   logic        next_prev_stage;
   logic        stage_rise;
   logic        stage_fall;
   logic        pol_rise;

   sp_state_t   sp_state;
   sp_state_t   next_sp_state;
   logic        sp_done;
   logic        eff_gate;

   logic        next_count_enable;
   logic        next_gate_level;

   logic        wr_gate;
   logic        wr_timer;

   // ==========================================================
   // Input synchronisers
   // ==========================================================
   pin_sync u_pin_sync (
      .clk_in    (clk_in),
      .rst_n_in  (rst_n_in),
      .ce_in     (ce_in),
      .async_in  (gate_pin_in),
      .level_out (pin_level)
   );

   // Comparator runs asynchronously to this clock, so it is always synchronised
   pin_sync u_cmp_sync (
      .clk_in    (clk_in),
      .rst_n_in  (rst_n_in),
      .ce_in     (ce_in),
      .async_in  (comparator_in),
      .level_out (cmp_level)
   );

   // ==========================================================
   // Gate source and polarity
   // ==========================================================
   always_comb begin
      case (ctrl.gate_source_select)
         SRC_PIN: begin
            src_level = pin_level;
         end
         SRC_T0_OVF: begin
            src_level = t0_overflow_in;
         end
         SRC_COMPARATOR: begin
            src_level = cmp_level;
         end
         default: begin
            src_level = 1'b0;
         end
      endcase
      pol_level     = ctrl.gate_polarity ? src_level : ~src_level;
      pol_rise      = pol_level & ~prev_pol;
      next_prev_pol = pol_level;
   end

   // ==========================================================
   // Toggle flip-flop
   // ==========================================================
   always_comb begin
      if (!ctrl.gate_toggle_mode || !timer_on) begin
         next_toggle_ff = 1'b0;
      end else if (pol_rise) begin
         next_toggle_ff = ~toggle_ff;
      end else begin
         next_toggle_ff = toggle_ff;
      end
      stage_level     = ctrl.gate_toggle_mode ? toggle_ff : pol_level;
      stage_rise      = stage_level & ~prev_stage;
      stage_fall      = ~stage_level & prev_stage;
      next_prev_stage = stage_level;
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         prev_pol   <= RESET_BIT;
         toggle_ff  <= RESET_BIT;
         prev_stage <= RESET_BIT;
      end else if (ce_in) begin
         prev_pol   <= next_prev_pol;
         toggle_ff  <= next_toggle_ff;
         prev_stage <= next_prev_stage;
      end
   end

   // ==========================================================
   // Single-pulse acquisition
   // ==========================================================
   // Arming waits for a fresh rising edge; a gate already high when
   // armed is not counted until it has gone low and high again.
   always_comb begin
      next_sp_state = sp_state;
      sp_done       = 1'b0;
      if (!ctrl.gate_single_pulse_mode) begin
         next_sp_state = SP_IDLE;
      end else begin
         case (sp_state)
            SP_IDLE: begin
               if (ctrl.single_pulse_go_done) begin
                  next_sp_state = SP_WAIT;
               end
            end
            SP_WAIT: begin
               if (!ctrl.single_pulse_go_done) begin
                  next_sp_state = SP_IDLE;
               end else if (stage_rise) begin
                  next_sp_state = SP_OPEN;
               end
            end
            SP_OPEN: begin
               if (stage_fall) begin
                  next_sp_state = SP_IDLE;
                  sp_done       = 1'b1;
               end
            end
            default: begin
               next_sp_state = SP_IDLE;
            end
         endcase
      end
      eff_gate = ctrl.gate_single_pulse_mode ? (sp_state == SP_OPEN) : stage_level;
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sp_state <= SP_IDLE;
      end else if (ce_in) begin
         sp_state <= next_sp_state;
      end
   end

   // ==========================================================
   // Registers
   // ==========================================================
   always_comb begin
      wr_gate       = wr_in && (addr_in == GATE_CTRL_OFFSET);
      wr_timer      = wr_in && (addr_in == TIMER_CTRL_OFFSET);
      next_ctrl     = ctrl;
      next_timer_on = timer_on;
      if (sp_done) begin
         next_ctrl.single_pulse_go_done = 1'b0;
      end
      // A write in the same cycle as completion wins, so a re-arm is kept
      if (wr_gate) begin
         next_ctrl.gate_enable            = wdata_in[GATE_ENABLE_BIT];
         next_ctrl.gate_polarity          = wdata_in[GATE_POLARITY_BIT];
         next_ctrl.gate_toggle_mode       = wdata_in[TOGGLE_MODE_BIT];
         next_ctrl.gate_single_pulse_mode = wdata_in[SINGLE_PULSE_BIT];
         next_ctrl.single_pulse_go_done   = wdata_in[GO_DONE_BIT];
         next_ctrl.gate_source_select     = wdata_in[SOURCE_MSB:SOURCE_LSB];
      end
      if (wr_timer) begin
         next_timer_on = wdata_in[TIMER_ON_BIT];
      end
   end

   always_comb begin
      next_rdata = RESET_RDATA;
      if (rd_in) begin
         case (addr_in)
            GATE_CTRL_OFFSET: begin
               next_rdata[GATE_ENABLE_BIT]       = ctrl.gate_enable;
               next_rdata[GATE_POLARITY_BIT]     = ctrl.gate_polarity;
               next_rdata[TOGGLE_MODE_BIT]       = ctrl.gate_toggle_mode;
               next_rdata[SINGLE_PULSE_BIT]      = ctrl.gate_single_pulse_mode;
               next_rdata[GO_DONE_BIT]           = ctrl.single_pulse_go_done;
               next_rdata[LEVEL_BIT]             = gate_level_out;
               next_rdata[SOURCE_MSB:SOURCE_LSB] = ctrl.gate_source_select;
            end
            TIMER_CTRL_OFFSET: begin
               next_rdata[TIMER_ON_BIT] = timer_on;
            end
            default: begin
               next_rdata = RESET_RDATA;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ctrl      <= RESET_CTRL;
         timer_on  <= RESET_BIT;
         rdata_out <= RESET_RDATA;
      end else if (ce_in) begin
         ctrl      <= next_ctrl;
         timer_on  <= next_timer_on;
         rdata_out <= next_rdata;
      end
   end

   // ==========================================================
   // Outputs to the counter
   // ==========================================================
   always_comb begin
      next_gate_level   = eff_gate;
      // Timer off overrides everything, gate enable included
      next_count_enable = timer_on && (!ctrl.gate_enable || eff_gate);
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         count_enable_out <= RESET_BIT;
         gate_level_out   <= RESET_BIT;
         timer_on_out     <= RESET_BIT;
         go_done_out      <= RESET_BIT;
      end else if (ce_in) begin
         count_enable_out <= next_count_enable;
         gate_level_out   <= next_gate_level;
         timer_on_out     <= next_timer_on;
         go_done_out      <= next_ctrl.single_pulse_go_done;
      end
   end

endmodule : timer_gate_control

// [tb/gate_source_model.sv]
`timescale 1ns/1ps
module gate_source_model (
   input  wire logic clk_in,
   input  wire logic pin_cmd_in,
   input  wire logic cmp_cmd_in,
   input  wire logic ovf_cmd_in,
   output logic      gate_pin_out,
   output logic      comparator_out,
   output logic      t0_overflow_out
);
   // ==========================================================
   // Sources
   // ==========================================================
   initial begin
      gate_pin_out = 1'b0;
      comparator_out = 1'b0;
   end
   // Async sources move off the clock edge, so sync flops are exercised
   always @(pin_cmd_in) gate_pin_out <= #13 pin_cmd_in;
   always @(cmp_cmd_in) comparator_out <= #31 cmp_cmd_in;
   // Overflow comes from a timer on the same clock
   always_ff @(posedge clk_in) t0_overflow_out <= ovf_cmd_in;
endmodule : gate_source_model

// [tb/timer_gate_control_monitor.sv]
`timescale 1ns/1ps
module timer_gate_control_monitor
   import gate_pkg::*;
(
   input wire logic              clk_in,
   input wire logic              rst_n_in,
   input wire logic [ADDR_W-1:0] addr_in,
   input wire logic [DATA_W-1:0] wdata_in,
   input wire logic              wr_in,
   input wire logic              rd_in,
   input wire logic [DATA_W-1:0] rdata_out,
   input wire logic              count_enable_out,
   input wire logic              timer_on_out,
   input wire logic              go_done_out
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);
   // ==========================================================
   // Register port
   // ==========================================================
   a_rdata_idle: assert property (!rd_in |=> rdata_out == 8'h00)
      else $error("read data not idle");
   a_timer_readback: assert property (rd_in && addr_in == TIMER_CTRL_OFFSET |=>
      rdata_out == {7'h00, $past(timer_on_out)}) else $error("timer control readback wrong");
   a_unmapped_zero: assert property (rd_in && addr_in > TIMER_CTRL_OFFSET |=> rdata_out == 8'h00)
      else $error("unmapped read not zero");
   a_go_readback: assert property (rd_in && addr_in == GATE_CTRL_OFFSET |=>
      rdata_out[GO_DONE_BIT] == $past(go_done_out)) else $error("go bit readback wrong");
   a_timer_on_write: assert property (wr_in && addr_in == TIMER_CTRL_OFFSET |=>
      timer_on_out == $past(wdata_in[TIMER_ON_BIT])) else $error("timer on not written");
   a_timer_on_hold: assert property (!(wr_in && addr_in == TIMER_CTRL_OFFSET) |=> $stable(timer_on_out))
      else $error("timer on changed without write");
   // ==========================================================
   // Gate control
   // ==========================================================
   a_go_arm: assert property (wr_in && addr_in == GATE_CTRL_OFFSET && wdata_in[GO_DONE_BIT]
      |=> go_done_out) else $error("go not armed");
   a_go_hw_clear: assert property (!(wr_in && addr_in == GATE_CTRL_OFFSET) |=> !$rose(go_done_out))
      else $error("go set by hardware");
   a_off_no_count: assert property (!timer_on_out |=> !count_enable_out)
      else $error("counting while timer off");
endmodule : timer_gate_control_monitor
bind timer_gate_control timer_gate_control_monitor timer_gate_control_monitor_i (.clk_in(clk_in),
   .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
   .rdata_out(rdata_out), .count_enable_out(count_enable_out), .timer_on_out(timer_on_out),
   .go_done_out(go_done_out));

// [tb/tb_timer_gate_control.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin miscompares++; \
   $display("mismatch at %0t got %h exp %h", $time, (a), (b)); end end
module tb_timer_gate_control
   import gate_pkg::*;
;
   logic              clk_in   = 1'b0;
   logic              rst_n_in = 1'b0;
   logic [ADDR_W-1:0] addr_in  = 4'h0;
   logic [DATA_W-1:0] wdata_in = 8'h00;
   logic [DATA_W-1:0] d;
   logic              wr_in = 1'b0, rd_in = 1'b0, pin = 1'b0, cmp = 1'b0, ovf = 1'b0;
   wire logic         gate_pin_in, t0_overflow_in, comparator_in;
   wire logic         count_enable_out, gate_level_out, timer_on_out, go_done_out;
   wire logic [7:0]   rdata_out;
   int                miscompares = 0, cmp_count = 0;

   always #25 clk_in = ~clk_in;

   gate_source_model gate_source_model_i (.clk_in(clk_in), .pin_cmd_in(pin), .cmp_cmd_in(cmp),
      .ovf_cmd_in(ovf), .gate_pin_out(gate_pin_in), .comparator_out(comparator_in),
      .t0_overflow_out(t0_overflow_in));
   timer_gate_control timer_gate_control_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(1'b1),
      .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .gate_pin_in(gate_pin_in),
      .t0_overflow_in(t0_overflow_in), .comparator_in(comparator_in), .rdata_out(rdata_out),
      .count_enable_out(count_enable_out), .gate_level_out(gate_level_out),
      .timer_on_out(timer_on_out), .go_done_out(go_done_out));

   // ==========================================================
   // Access tasks
   // ==========================================================
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk_in);
      addr_in <= a;
      wdata_in <= v;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a);
      @(posedge clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1;
      d = rdata_out;
   endtask : rd
   // Sync flops plus toggle and pulse stages need well under ten edges
   task automatic gate(input logic p, input logic c, input logic o);
      @(posedge clk_in);
      pin <= p;
      cmp <= c;
      ovf <= o;
      repeat (10) @(posedge clk_in);
      #1;
   endtask : gate
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : summarize

   // ==========================================================
   // Tests
   // ==========================================================
   initial begin
      repeat (12) @(posedge clk_in);
      rst_n_in <= 1'b1;
      rd(GATE_CTRL_OFFSET);
      `CHK(d & 8'hfb, RESET_RDATA)
      `CHK(d[LEVEL_BIT], 1'b1)
      rd(4'h7);
      `CHK(d, 8'h00)
      wr(TIMER_CTRL_OFFSET, 8'hff);
      rd(TIMER_CTRL_OFFSET);
      `CHK(d, 8'h01)
      `CHK(timer_on_out, 1'b1)
      gate(1'b0, 1'b0, 1'b0);
      `CHK(count_enable_out, 1'b1)
      for (int s = 0; s < 3; s++) begin
         wr(GATE_CTRL_OFFSET, 8'hc0 | 8'(s));
         gate(s == 0, s == 2, s == 1);
         `CHK({count_enable_out, gate_level_out}, 2'b11)
         gate(1'b0, 1'b0, 1'b0);
         `CHK(count_enable_out, 1'b0)
      end
      wr(GATE_CTRL_OFFSET, 8'h80);
      gate(1'b0, 1'b0, 1'b0);
      `CHK(count_enable_out, 1'b1)
      rd(GATE_CTRL_OFFSET);
      `CHK(d, 8'h84)
      wr(GATE_CTRL_OFFSET, 8'hc3);
      gate(1'b1, 1'b1, 1'b1);
      `CHK(count_enable_out, 1'b0)
      rd(GATE_CTRL_OFFSET);
      `CHK(d & 8'hfb, 8'hc3)
      wr(TIMER_CTRL_OFFSET, 8'h00);
      wr(GATE_CTRL_OFFSET, 8'h00);
      // Pin left low so the polarity flip below makes no toggle edge
      gate(1'b0, 1'b0, 1'b0);
      `CHK(count_enable_out, 1'b0)
      wr(TIMER_CTRL_OFFSET, 8'h01);
      wr(GATE_CTRL_OFFSET, 8'he0);
      gate(1'b0, 1'b0, 1'b0);
      `CHK(gate_level_out, 1'b0)
      gate(1'b1, 1'b0, 1'b0);
      `CHK(gate_level_out, 1'b1)
      gate(1'b0, 1'b0, 1'b0);
      `CHK(gate_level_out, 1'b1)
      gate(1'b1, 1'b0, 1'b0);
      `CHK(gate_level_out, 1'b0)
      gate(1'b0, 1'b0, 1'b0);
      gate(1'b1, 1'b0, 1'b0);
      wr(TIMER_CTRL_OFFSET, 8'h00);
      wr(TIMER_CTRL_OFFSET, 8'h01);
      gate(1'b1, 1'b0, 1'b0);
      `CHK(gate_level_out, 1'b0)
      gate(1'b0, 1'b0, 1'b0);
      gate(1'b1, 1'b0, 1'b0);
      wr(GATE_CTRL_OFFSET, 8'hc0);
      gate(1'b0, 1'b0, 1'b0);
      wr(GATE_CTRL_OFFSET, 8'he0);
      gate(1'b0, 1'b0, 1'b0);
      `CHK(gate_level_out, 1'b0)
      wr(GATE_CTRL_OFFSET, 8'hd8);
      gate(1'b0, 1'b0, 1'b0);
      `CHK({go_done_out, gate_level_out}, 2'b10)
      gate(1'b1, 1'b0, 1'b0);
      `CHK({go_done_out, gate_level_out}, 2'b11)
      gate(1'b0, 1'b0, 1'b0);
      `CHK({go_done_out, gate_level_out}, 2'b00)
      rd(GATE_CTRL_OFFSET);
      `CHK(d[GO_DONE_BIT], 1'b0)
      gate(1'b1, 1'b0, 1'b0);
      `CHK(gate_level_out, 1'b0)
      wr(GATE_CTRL_OFFSET, 8'hd8);
      wr(GATE_CTRL_OFFSET, 8'hd0);
      gate(1'b0, 1'b0, 1'b0);
      `CHK(go_done_out, 1'b0)
      summarize();
   end

   initial begin
      #2000000;
      miscompares++;
      summarize();
   end
endmodule : tb_timer_gate_control
